// >>> src/msid_pkg.sv
package msid_pkg;

  // Sizes of the decoder
  localparam int NCPU      = 8;
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;
  localparam int PAYLOAD_W = 16;
  localparam int ID_W      = 8;

  // Fixed pattern in the top address bits that marks an interrupt message
  localparam logic [11:0] MSG_WINDOW = 12'h0FEE;

  // Address word field positions
  localparam int WIN_HI = 31;
  localparam int WIN_LO = 20;
  localparam int TGT_HI = 19;
  localparam int TGT_LO = 12;
  localparam int RH_BIT = 3;
  localparam int DM_BIT = 2;

  // Payload word field positions
  localparam int VEC_HI    = 7;
  localparam int VEC_LO    = 0;
  localparam int MODE_HI   = 10;
  localparam int MODE_LO   = 8;
  localparam int LEVEL_BIT = 14;
  localparam int TRIG_BIT  = 15;

  // Cluster split of a logical identifier
  localparam int CL_HI  = 7;
  localparam int CL_LO  = 4;
  localparam int MEM_HI = 3;
  localparam int MEM_LO = 0;

  // Vector sent when the delivery kind discards it
  localparam logic [ID_W-1:0] VEC_NONE = 8'h00;

  // Delivery kinds
  typedef enum logic [2:0] {
    DLV_FIXED   = 3'h0,
    DLV_LOWEST  = 3'h1,
    DLV_SYSMGMT = 3'h2,
    DLV_RSVD3   = 3'h3,
    DLV_NMI     = 3'h4,
    DLV_INIT    = 3'h5,
    DLV_RSVD6   = 3'h6,
    DLV_EXTCTL  = 3'h7
  } msid_mode_type;

  typedef enum logic [0:0] {
    PH_IDLE = 1'h0,
    PH_HELD = 1'h1
  } msid_phase_type;

  // Per-processor settings of a local interrupt unit
  typedef struct packed {
    logic            enabled;
    logic            flatModel;
    logic [ID_W-1:0] physId;
    logic [ID_W-1:0] logicalId;
    logic [ID_W-1:0] taskPrio;
  } msid_cpu_cfg_type;

  // Message as handed to the processors
  typedef struct packed {
    logic [ID_W-1:0] vector;
    msid_mode_type   mode;
    logic            levelTrig;
    logic            assertLvl;
  } msid_info_type;

  // Complete state of the decoder
  typedef struct packed {
    msid_phase_type       phase;
    logic                 memValid;
    logic [ADDR_W-1:0]    memAddr;
    logic [DATA_W-1:0]    memData;
    logic [ADDR_W-1:0]    msgAddr;
    logic [PAYLOAD_W-1:0] msgPayload;
    logic [NCPU-1:0]      deliver;
    logic [NCPU-1:0]      intrRaise;
    msid_info_type        info;
    logic                 dropped;
  } msid_state_type;

endpackage

// >>> src/msid_target_match.sv
`timescale 1ns/1ps
module msid_target_match (
  // Decoded address fields and the lowest priority select
  input  wire logic [msid_pkg::ID_W-1:0]               target,
  input  wire logic                                    redirHint,
  input  wire logic                                    destInterp,
  input  wire logic                                    lowestSel,
  // Processor settings
  input  wire msid_pkg::msid_cpu_cfg_type [msid_pkg::NCPU-1:0] cpuCfg,
  // Match results
  output logic [msid_pkg::NCPU-1:0]                    physMatch,
  output logic [msid_pkg::NCPU-1:0]                    logMatch,
  output logic [msid_pkg::NCPU-1:0]                    pick
);

  logic [msid_pkg::NCPU-1:0] cand;

  // Flat model: any common bit; cluster model: same cluster, common member bit
  function automatic logic logical_hit(input msid_pkg::msid_cpu_cfg_type c,
                                       input logic [msid_pkg::ID_W-1:0] t);
    logic hit;
    if (c.flatModel) begin
      hit = |(c.logicalId & t);
    end else begin
      hit = (c.logicalId[msid_pkg::CL_HI:msid_pkg::CL_LO] == t[msid_pkg::CL_HI:msid_pkg::CL_LO])
          && |(c.logicalId[msid_pkg::MEM_HI:msid_pkg::MEM_LO]
               & t[msid_pkg::MEM_HI:msid_pkg::MEM_LO]);
    end
    return hit;
  endfunction

  // Disabled processors never match, so a bad identifier cannot reach them
  genvar gi;
  generate
    for (gi = 0; gi < msid_pkg::NCPU; gi++) begin : g_cpu
      assign physMatch[gi] = cpuCfg[gi].enabled && (cpuCfg[gi].physId == target); // R9
      assign logMatch[gi]  = cpuCfg[gi].enabled && logical_hit(cpuCfg[gi], target); // R10
    end
  endgenerate

  // Logical set only with hint and logical interpretation both set
  assign cand = (redirHint && destInterp) ? logMatch : physMatch; // R4 R5

  // Lowest priority pick; ties go to the lowest index
  always_comb begin
    logic [msid_pkg::ID_W-1:0] best;
    logic                      found;
    best  = '0;
    found = 1'b0;
    pick  = '0;
    for (int i = 0; i < msid_pkg::NCPU; i++) begin
      if (cand[i] && (!found || cpuCfg[i].taskPrio < best)) begin
        best  = cpuCfg[i].taskPrio;
        found = 1'b1;
        pick  = '0;
        pick[i] = 1'b1; // R14
      end
    end
    if (!lowestSel) begin
      pick = cand; // R13
    end
  end

endmodule

// >>> src/msid_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// R1: Only addresses whose top twelve bits carry the fixed pattern are interrupt messages.
// R2: Every write inside the one-megabyte window is routed as a message, never memory.
// R3: Address bits carry an eight-bit target identifier naming receiving processors.
// R4: Hint clear delivers to the processor named by the target identifier.
// R5: Hint clear ignores the destination interpretation bit entirely.
// R6: Requester avoids all-ones physical target and names present enabled processors.
// R7: Flat logical targets set only bits of present enabled processors.
// R8: Cluster logical targets avoid all-ones and select only present enabled processors.
// R9: Hint set, physical interpretation: only the matching physical identifier, no redirection.
// R10: Hint and logical interpretation set: redirect among logically matching processors only.
// R11: Reserved payload bits are preserved by software and ignored here.
// R12: Requester keeps the vector between 010H and 0FEH.
// R13: Fixed code delivers to every listed processor, edge or level.
// R14: Lowest priority code delivers to the single lowest-priority listed processor.
// R15: System management code is edge only and its vector is ignored.
// R16: Non-maskable code goes to all listed, vector dropped, always edge.
// R17: Initialisation code goes to all listed, vector dropped, always edge.
// R18: External controller code raises the maskable request input of listed processors.
// R19: Edge messages always assert; level messages carry the level bit.
// R20: Trigger bit zero means edge, one means level.
// R21: Requester sends each interrupt as one doubleword memory write.
// R22: Undefined delivery codes 011B and 110B are dropped undelivered.
// R23: Fields sit at the standard message address and payload positions.
module msid_decoder (
  // Clock and reset
  input  wire logic                                        clk,
  input  wire logic                                        nrst,
  // Doubleword write path from the requesting function
  input  wire logic                                        wrValid,
  input  wire logic [msid_pkg::ADDR_W-1:0]                 wrAddr,
  input  wire logic [msid_pkg::DATA_W-1:0]                 wrData,
  // Ordinary memory traffic passed on
  output logic                                             memValid,
  output logic [msid_pkg::ADDR_W-1:0]                      memAddr,
  output logic [msid_pkg::DATA_W-1:0]                      memData,
  // Local interrupt unit settings
  input  wire msid_pkg::msid_cpu_cfg_type [msid_pkg::NCPU-1:0] cpuCfg,
  // Delivery to the processors
  output logic [msid_pkg::NCPU-1:0]                        intDeliver,
  output logic [msid_pkg::NCPU-1:0]                        intrRaise,
  output msid_pkg::msid_info_type                          intInfo,
  output logic                                             msgDropped,
  // Last captured message words
  output logic [msid_pkg::ADDR_W-1:0]                      msgAddrQ,
  output logic [msid_pkg::PAYLOAD_W-1:0]                   msgPayloadQ
);

  msid_pkg::msid_state_type s_q;
  msid_pkg::msid_state_type s_d;

  logic                          inWindow;
  logic [msid_pkg::ID_W-1:0]     target;
  logic                          redirHint;
  logic                          destInterp;
  msid_pkg::msid_mode_type       mode;
  logic [msid_pkg::ID_W-1:0]     vecField;
  logic                          levelBit;
  logic                          trigBit;
  logic [msid_pkg::NCPU-1:0]     physMatch;
  logic [msid_pkg::NCPU-1:0]     logMatch;
  logic [msid_pkg::NCPU-1:0]     pick;
  logic                          held;

  // Window test on the incoming address
  assign inWindow = wrAddr[msid_pkg::WIN_HI:msid_pkg::WIN_LO] == msid_pkg::MSG_WINDOW; // R1

  // Field split of the held message; reserved bits are never looked at
  assign target     = s_q.msgAddr[msid_pkg::TGT_HI:msid_pkg::TGT_LO]; // R3
  assign redirHint  = s_q.msgAddr[msid_pkg::RH_BIT]; // R23
  assign destInterp = s_q.msgAddr[msid_pkg::DM_BIT]; // R23
  assign mode       = msid_pkg::msid_mode_type'(s_q.msgPayload[msid_pkg::MODE_HI:msid_pkg::MODE_LO]);
  assign vecField   = s_q.msgPayload[msid_pkg::VEC_HI:msid_pkg::VEC_LO]; // R11
  assign levelBit   = s_q.msgPayload[msid_pkg::LEVEL_BIT];
  assign trigBit    = s_q.msgPayload[msid_pkg::TRIG_BIT];
  assign held       = s_q.phase == msid_pkg::PH_HELD;

  // Target selection; disabled units are screened out there
  msid_target_match u_match (
    .target     (target),
    .redirHint  (redirHint),
    .destInterp (destInterp),
    .lowestSel  (mode == msid_pkg::DLV_LOWEST),
    .cpuCfg     (cpuCfg),
    .physMatch  (physMatch),
    .logMatch   (logMatch),
    .pick       (pick)
  );

  // Next state: deliver the held message, then take a new write
  always_comb begin
    s_d           = s_q;
    s_d.memValid  = 1'b0;
    s_d.deliver   = '0;
    s_d.intrRaise = '0;
    s_d.dropped   = 1'b0;
    if (held) begin
      s_d.phase     = msid_pkg::PH_IDLE;
      s_d.info.mode = mode;
      case (mode)
        msid_pkg::DLV_FIXED,
        msid_pkg::DLV_LOWEST: begin
          s_d.deliver        = pick; // R13 R14
          s_d.info.vector    = vecField;
          s_d.info.levelTrig = trigBit; // R20
        end
        msid_pkg::DLV_SYSMGMT,
        msid_pkg::DLV_NMI,
        msid_pkg::DLV_INIT: begin
          s_d.deliver        = pick;
          s_d.info.vector    = msid_pkg::VEC_NONE; // R15 R16 R17
          s_d.info.levelTrig = 1'b0; // R15 R16 R17
        end
        msid_pkg::DLV_EXTCTL: begin
          // Vector comes later from the acknowledge cycle
          s_d.intrRaise      = pick; // R18
          s_d.info.vector    = msid_pkg::VEC_NONE;
          s_d.info.levelTrig = 1'b0; // R18
        end
        default: begin
          s_d.dropped = 1'b1; // R22
        end
      endcase
      // A message with no willing receiver is reported, not silently lost
      if (pick == '0) begin
        s_d.dropped = 1'b1;
      end
      // Edge messages are always assertions
      s_d.info.assertLvl = s_d.info.levelTrig ? levelBit : 1'b1; // R19
    end
    // Writes are always taken; a message behind one in delivery just queues one deep
    if (wrValid) begin
      if (inWindow) begin
        s_d.phase      = msid_pkg::PH_HELD; // R2 R21
        s_d.msgAddr    = wrAddr;
        s_d.msgPayload = wrData[msid_pkg::PAYLOAD_W-1:0];
      end else begin
        s_d.memValid = 1'b1; // R1
        s_d.memAddr  = wrAddr;
        s_d.memData  = wrData;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state
  assign memValid    = s_q.memValid;
  assign memAddr     = s_q.memAddr;
  assign memData     = s_q.memData;
  assign intDeliver  = s_q.deliver;
  assign intrRaise   = s_q.intrRaise;
  assign intInfo     = s_q.info;
  assign msgDropped  = s_q.dropped;
  assign msgAddrQ    = s_q.msgAddr;
  assign msgPayloadQ = s_q.msgPayload;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Window writes never leak to memory and are delivered or dropped two cycles later
  window_route_a: assert property ( // R2
    wrValid && inWindow |=> !memValid ##1 (intDeliver != '0 || intrRaise != '0 || msgDropped)
  ) else $error("window write not routed as message");

  // Writes outside the window go out as memory traffic unchanged
  mem_pass_a: assert property ( // R1
    wrValid && !inWindow |=> memValid && memAddr == $past(wrAddr) && memData == $past(wrData)
  ) else $error("memory write not forwarded");

  // Hint clear: physical target only, interpretation bit ignored
  hint_clear_a: assert property ( // R4
    held && !redirHint && mode == msid_pkg::DLV_FIXED |=> intDeliver == $past(physMatch)
  ) else $error("hint clear delivery wrong");

  // Hint set, physical: at most the one matching unit
  phys_nored_a: assert property ( // R9
    held && redirHint && !destInterp && mode == msid_pkg::DLV_NMI
    |=> intDeliver == $past(physMatch)
  ) else $error("physical hint delivery wrong");

  // Hint and logical set: logical group only
  logical_group_a: assert property ( // R10
    held && redirHint && destInterp && mode == msid_pkg::DLV_FIXED
    |=> intDeliver == $past(logMatch)
  ) else $error("logical group delivery wrong");

  // Lowest priority reaches at most one unit of the candidate set
  lowest_one_a: assert property ( // R14
    held && mode == msid_pkg::DLV_LOWEST
    |=> $onehot0(intDeliver) && (intDeliver & ~$past(redirHint && destInterp ?
        logMatch : physMatch)) == '0
  ) else $error("lowest priority pick wrong");

  // Non-maskable and initialisation: edge, no vector
  forced_edge_a: assert property ( // R16
    held && (mode == msid_pkg::DLV_NMI || mode == msid_pkg::DLV_INIT)
    |=> !intInfo.levelTrig && intInfo.vector == msid_pkg::VEC_NONE && intInfo.assertLvl
  ) else $error("forced edge kind wrong");

  // External controller drives the request input, not the normal path
  ext_raise_a: assert property ( // R18
    held && mode == msid_pkg::DLV_EXTCTL |=> intrRaise == $past(pick) && intDeliver == '0
  ) else $error("external controller raise wrong");

  // Undefined codes reach nobody
  rsvd_drop_a: assert property ( // R22
    held && (mode == msid_pkg::DLV_RSVD3 || mode == msid_pkg::DLV_RSVD6)
    |=> msgDropped && intDeliver == '0 && intrRaise == '0
  ) else $error("reserved code delivered");

  // Fixed kind keeps trigger bit and level bit
  trig_keep_a: assert property ( // R20
    held && mode == msid_pkg::DLV_FIXED
    |=> intInfo.levelTrig == $past(trigBit)
        && intInfo.assertLvl == ($past(trigBit) ? $past(levelBit) : 1'b1)
  ) else $error("trigger or level wrong");

  // Pulses last one cycle when nothing new arrives
  pulse_short_a: assert property ( // R13
    (intDeliver != '0) && !$past(wrValid) |=> intDeliver == '0
  ) else $error("delivery held too long");

  // Window write address word and low payload half of the data word are captured for the next cycle
  msg_capture_a: assert property ( // R2
    wrValid && inWindow |=> msgAddrQ == $past(wrAddr)
        && msgPayloadQ == $past(wrData[msid_pkg::PAYLOAD_W-1:0])
  ) else $error("message words not captured");

  // No write, no memory pulse
  mem_quiet_a: assert property ( // R1
    !wrValid |=> !memValid
  ) else $error("spurious memory write");

  // Nothing held, nothing delivered or reported
  idle_quiet_a: assert property ( // R2
    !held |=> intDeliver == '0 && intrRaise == '0 && !msgDropped
  ) else $error("delivery without message");

  // System management kind: edge, no vector
  sysmgmt_edge_a: assert property ( // R15
    held && mode == msid_pkg::DLV_SYSMGMT
    |=> !intInfo.levelTrig && intInfo.vector == msid_pkg::VEC_NONE && intInfo.assertLvl
  ) else $error("system management kind wrong");

  // Initialisation reaches the whole listed set
  init_all_a: assert property ( // R17
    held && mode == msid_pkg::DLV_INIT
    |=> intDeliver == $past(redirHint && destInterp ? logMatch : physMatch) && intrRaise == '0
  ) else $error("initialisation set wrong");

  // Non-maskable reaches the whole listed set
  nmi_all_a: assert property ( // R16
    held && mode == msid_pkg::DLV_NMI
    |=> intDeliver == $past(redirHint && destInterp ? logMatch : physMatch) && intrRaise == '0
  ) else $error("non-maskable set wrong");

  // Fixed kind reaches the whole listed set with its vector
  fixed_all_a: assert property ( // R13
    held && mode == msid_pkg::DLV_FIXED
    |=> intDeliver == $past(redirHint && destInterp ? logMatch : physMatch)
        && intInfo.vector == $past(vecField)
  ) else $error("fixed set wrong");

  // Lowest priority keeps vector and trigger bit
  lowest_info_a: assert property ( // R20
    held && mode == msid_pkg::DLV_LOWEST
    |=> intInfo.vector == $past(vecField) && intInfo.levelTrig == $past(trigBit)
  ) else $error("lowest priority info wrong");

  // Level lowest priority carries the level bit
  level_pass_a: assert property ( // R19
    held && mode == msid_pkg::DLV_LOWEST && trigBit |=> intInfo.assertLvl == $past(levelBit)
  ) else $error("level bit not carried");

  // External kind is edge with no vector
  ext_edge_a: assert property ( // R18
    held && mode == msid_pkg::DLV_EXTCTL
    |=> !intInfo.levelTrig && intInfo.vector == msid_pkg::VEC_NONE && intInfo.assertLvl
  ) else $error("external kind info wrong");

  // Only the external kind touches the request inputs
  raise_only_ext_a: assert property ( // R18
    held && mode != msid_pkg::DLV_EXTCTL |=> intrRaise == '0
  ) else $error("request input raised wrongly");

  // Edge messages of a defined kind always assert
  edge_assert_a: assert property ( // R19
    held && !trigBit && mode != msid_pkg::DLV_RSVD3 && mode != msid_pkg::DLV_RSVD6
    |=> intInfo.assertLvl
  ) else $error("edge message not an assertion");

  // Empty receiver set is reported and reaches nobody
  empty_drop_a: assert property ( // R22
    held && pick == '0 |=> msgDropped && intDeliver == '0 && intrRaise == '0
  ) else $error("empty set not dropped");

  // Defined kind with a receiver is never reported dropped
  drop_only_a: assert property ( // R22
    held && mode != msid_pkg::DLV_RSVD3 && mode != msid_pkg::DLV_RSVD6 && pick != '0
    |=> !msgDropped
  ) else $error("delivered message reported dropped");

  // Kind reported with every delivery
  mode_report_a: assert property ( // R23
    held |=> intInfo.mode == $past(mode)
  ) else $error("reported kind wrong");

endmodule

// >>> testbench/msid_requester.sv
`timescale 1ns/1ps
module msid_requester (
  // Clock
  input  wire logic                   clk,
  // Write path toward the decoder
  output logic                        wrValid,
  output logic [msid_pkg::ADDR_W-1:0] wrAddr,
  output logic [msid_pkg::DATA_W-1:0] wrData
);
  // Quiet bus at time zero
  initial begin
    wrValid = 1'b0;
    wrAddr  = 32'h0000_0000;
    wrData  = 32'h0000_0000;
  end

  // One doubleword write per interrupt, launched at the falling edge
  task automatic send(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk);
    wrValid = 1'b1;
    wrAddr  = a;
    wrData  = d;
    @(negedge clk);
    wrValid = 1'b0;
    // Inverted leftovers, so a stale word never looks valid
    wrAddr  = ~a;
    wrData  = ~d;
  endtask
endmodule

// >>> testbench/msid_decoder_bench.sv
`timescale 1ns/1ps
module msid_decoder_bench;
  logic                                        clk;
  logic                                        nrst;
  logic                                        wrValid;
  logic [31:0]                                 wrAddr;
  logic [31:0]                                 wrData;
  logic                                        memValid;
  logic [31:0]                                 memAddr;
  logic [31:0]                                 memData;
  msid_pkg::msid_cpu_cfg_type [msid_pkg::NCPU-1:0] cpuCfg;
  logic [7:0]                                  intDeliver;
  logic [7:0]                                  intrRaise;
  msid_pkg::msid_info_type                     intInfo;
  logic                                        msgDropped;
  logic [31:0]                                 msgAddrQ;
  logic [15:0]                                 msgPayloadQ;
  int                                          n_errors;
  int                                          comparisons;

  msid_requester req (.clk(clk), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData));

  msid_decoder dut (
    .clk(clk), .nrst(nrst), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
    .memValid(memValid), .memAddr(memAddr), .memData(memData), .cpuCfg(cpuCfg),
    .intDeliver(intDeliver), .intrRaise(intrRaise), .intInfo(intInfo),
    .msgDropped(msgDropped), .msgAddrQ(msgAddrQ), .msgPayloadQ(msgPayloadQ)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Message address and payload words in the standard layout
  function automatic logic [31:0] adr(input logic [7:0] t, input logic h, input logic l);
    return {12'h0FEE, t, 8'h00, h, l, 2'b00};
  endfunction
  function automatic logic [31:0] dat(input logic tr, input logic lv, input logic [2:0] m,
                                      input logic [7:0] v);
    return {16'hA5A5, tr, lv, 3'b000, m, v};
  endfunction

  // One message, judged at capture and at delivery
  task automatic msg(input logic [31:0] a, input logic [31:0] d, input logic [7:0] eDel,
                     input logic [7:0] eRaise, input logic eDrop, input logic [12:0] eInfo);
    req.send(a, d);
    chk(32'(memValid), 32'h0000_0000);
    chk(msgAddrQ, a);
    chk(32'(msgPayloadQ), 32'(d[15:0]));
    @(negedge clk);
    chk(32'(intDeliver), 32'(eDel));
    chk(32'(intrRaise), 32'(eRaise));
    chk(32'(msgDropped), 32'(eDrop));
    if (!eDrop)
      chk(32'(intInfo), 32'(eInfo));
  endtask

  // Writes just outside the window stay ordinary memory traffic
  task automatic t_memory();
    logic [31:0] a;
    for (int i = 0; i < 2; i++) begin
      a = i ? 32'hFEF0_0000 : 32'hFEDF_FFFC;
      req.send(a, 32'h1234_5678);
      chk(32'(memValid), 32'h0000_0001);
      chk(memAddr, a);
      chk(memData, 32'h1234_5678);
      @(negedge clk);
      chk(32'(intDeliver | intrRaise), 32'h0000_0000);
      chk(32'(memValid), 32'h0000_0000);
    end
    $display("Test memory done");
  endtask

  task automatic t_fixed();
    msg(adr(8'h03, 1'b0, 1'b1), dat(1'b1, 1'b1, 3'h0, 8'h41), 8'h08, 8'h00, 1'b0,
        {8'h41, 3'h0, 2'b11});
    msg(adr(8'h03, 1'b0, 1'b0), dat(1'b1, 1'b0, 3'h0, 8'h42), 8'h08, 8'h00, 1'b0,
        {8'h42, 3'h0, 2'b10});
    msg(adr(8'h04, 1'b0, 1'b0), dat(1'b0, 1'b0, 3'h0, 8'h43), 8'h10, 8'h00, 1'b0,
        {8'h43, 3'h0, 2'b01});
    $display("Test fixed done");
  endtask

  task automatic t_redirect();
    msg(adr(8'h0E, 1'b1, 1'b1), dat(1'b0, 1'b0, 3'h1, 8'h50), 8'h08, 8'h00, 1'b0,
        {8'h50, 3'h1, 2'b01});
    msg(adr(8'h02, 1'b1, 1'b0), dat(1'b0, 1'b0, 3'h1, 8'h51), 8'h04, 8'h00, 1'b0,
        {8'h51, 3'h1, 2'b01});
    msg(adr(8'h0E, 1'b1, 1'b1), dat(1'b0, 1'b0, 3'h0, 8'h52), 8'h0E, 8'h00, 1'b0,
        {8'h52, 3'h0, 2'b01});
    $display("Test redirect done");
  endtask

  // Vector-less kinds, external kind and reserved codes
  task automatic t_kinds();
    logic [2:0] m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 3'h2 : (i == 1) ? 3'h4 : 3'h5;
      // System management is sent edge with a zero vector, as the requester owes
      msg(adr(8'h05, 1'b0, 1'b0), dat(1'(i != 0), 1'b0, m, (i == 0) ? 8'h00 : 8'h55), 8'h20,
          8'h00, 1'b0, {8'h00, m, 2'b01});
    end
    msg(adr(8'h05, 1'b0, 1'b0), dat(1'b0, 1'b0, 3'h7, 8'h55), 8'h00, 8'h20, 1'b0,
        {8'h00, 3'h7, 2'b01});
    // Unit 7 is disabled, so nobody is listed and the message is dropped
    msg(adr(8'h07, 1'b0, 1'b0), dat(1'b0, 1'b0, 3'h0, 8'h58), 8'h00, 8'h00, 1'b1,
        13'h0000);
    msg(adr(8'h05, 1'b0, 1'b0), dat(1'b0, 1'b0, 3'h3, 8'h56), 8'h00, 8'h00, 1'b1,
        13'h0000);
    msg(adr(8'h05, 1'b0, 1'b0), dat(1'b0, 1'b0, 3'h6, 8'h57), 8'h00, 8'h00, 1'b1,
        13'h0000);
    $display("Test kinds done");
  endtask

  // Watchdog sized well beyond the expected run
  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end

  // Flat logical ids one bit each; unit 3 runs at the lowest priority of 1..3
  initial begin
    n_errors    = 0;
    comparisons = 0;
    nrst        = 1'b0;
    for (int i = 0; i < 8; i++) begin
      cpuCfg[i].enabled   = (i != 7);
      cpuCfg[i].flatModel = 1'b1;
      cpuCfg[i].physId    = 8'(i);
      cpuCfg[i].logicalId = 8'(1 << i);
      cpuCfg[i].taskPrio  = 8'(8'h80 - 8 * i);
    end
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_memory();
    t_fixed();
    t_redirect();
    t_kinds();
    tally_and_finish();
  end
endmodule
